// File: core/dsalt_pkg.sv
// shared constants for the dual-slope altitude linearizer
`default_nettype none

package dsalt_pkg;

  // fixed integration phase and full-scale discharge, in clock periods
  localparam int FIXED_INTEGRATE_CLKS = 2048;
  localparam int DISCHARGE_MAX_CLKS = 1676;
  localparam int PHASE_W = 12;

  // altitude range: 510 steps of 100 ft above the lowest point
  localparam int ALT_W = 9;
  localparam int ALT_STEPS = 510;
  localparam int ALT_ROM_DEPTH = 512;

  // width of one delta word; must encode the max/min slope ratio
  localparam int DELTA_W = 3;
  localparam int DELTA_MAX = 6;
  localparam int DELTA_MIN = 1;

  // digital pressure input width
  localparam int PRESS_W = 11;

  // decimal preset: minus ten hundreds of feet
  localparam logic dec_preset_neg = 1'h1;
  localparam logic [3:0] DEC_PRESET_D2 = 4'h0;
  localparam logic [3:0] DEC_PRESET_D1 = 4'h1;
  localparam logic [3:0] DEC_PRESET_D0 = 4'h0;

  // conversion sequencer states
  typedef enum logic [1:0] {
    DSALT_IDLE,
    DSALT_INTEGRATE,
    DSALT_DISCHARGE,
    DSALT_DIGITAL
  } dsalt_state_e;

endpackage

`default_nettype wire

// File: core/dsalt_delta_rom.sv
`timescale 1ns/1ps
`default_nettype none

// delta table: pressure increments between one altitude step and the next
module dsalt_delta_rom #(
  parameter int ADDR_W = dsalt_pkg::ALT_W,
  parameter int DATA_W = dsalt_pkg::DELTA_W,
  parameter int DEPTH = dsalt_pkg::ALT_ROM_DEPTH
) (
  // altitude step index
  input wire logic [ADDR_W-1:0] addr,
  // increments needed at this step
  output logic [DATA_W-1:0] data
);

  // default curve: steepest at the bottom
  function automatic int delta_of(input int idx);
    int span;
    span = dsalt_pkg::DELTA_MAX - dsalt_pkg::DELTA_MIN;
    return dsalt_pkg::DELTA_MIN + ((DEPTH - 1 - idx) * span) / (DEPTH - 1);
  endfunction

  logic [DATA_W-1:0] mem [DEPTH];

  // width must hold the largest delta
  if (DATA_W < $clog2(dsalt_pkg::DELTA_MAX + 1) || DEPTH > (1 << ADDR_W)) begin : g_chk
    $error("dsalt_delta_rom: width or depth out of range");
  end

  // table filled from constants, one word per altitude step
  for (genvar i = 0; i < DEPTH; i++) begin : g_fill
    assign mem[i] = DATA_W'(delta_of(i)); // [RULE1]
  end

  assign data = mem[addr]; // [RULE1]

endmodule // dsalt_delta_rom

`default_nettype wire

// File: core/dsalt_linearizer.sv
// Contract
// RULE1 - rom indexed by step, words encode slope ratio
// RULE2 - start lowest; step after rom count elapses
// RULE3 - rom output follows each new altitude
// RULE4 - hold result in nine-bit counter
// RULE5 - digital pressure counts down; altitude counts up
// RULE6 - input current fixed time, then reference
// RULE7 - both phases measured in clock periods
// RULE8 - integration lasts exactly 2048 periods
// RULE9 - discharge may run 1676 periods
// RULE10 - after trip: reference off, input on
// RULE11 - decimal counter preset minus 1000 steps along
// RULE12 - start clears counters and rom address
`timescale 1ns/1ps
`default_nettype none

module dsalt_linearizer #(
  parameter int INTEGRATE_CLKS = dsalt_pkg::FIXED_INTEGRATE_CLKS,
  parameter int DISCHARGE_CLKS = dsalt_pkg::DISCHARGE_MAX_CLKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion request
  input wire logic start,
  input wire logic digital_mode,
  input wire logic [dsalt_pkg::PRESS_W-1:0] digital_pressure,
  // analog front end
  input wire logic comparator,
  output logic input_current_en,
  output logic ref_current_en,
  // status
  output logic busy,
  output logic done,
  output logic overrange,
  // results
  output logic [dsalt_pkg::ALT_W-1:0] altitude,
  output logic [dsalt_pkg::PHASE_W-1:0] discharge_period,
  output logic dec_negative,
  output logic [3:0] dec_digit2,
  output logic [3:0] dec_digit1,
  output logic [3:0] dec_digit0
);

  localparam int PW = dsalt_pkg::PHASE_W;
  localparam int AW = dsalt_pkg::ALT_W;
  localparam int DW = dsalt_pkg::DELTA_W;
  localparam int PRW = dsalt_pkg::PRESS_W;
  localparam logic [PW-1:0] INT_LAST = PW'(INTEGRATE_CLKS - 1);
  localparam logic [PW-1:0] DIS_LAST = PW'(DISCHARGE_CLKS - 1);
  localparam logic [AW-1:0] ALT_TOP = AW'(dsalt_pkg::ALT_STEPS);

  // the phase counter must reach both periods
  if (INTEGRATE_CLKS < 1 || DISCHARGE_CLKS < 1 || INTEGRATE_CLKS > (1 << PW)
      || DISCHARGE_CLKS >= (1 << PW)) begin : g_chk
    $error("dsalt_linearizer: phase lengths do not fit the phase counter");
  end

  dsalt_pkg::dsalt_state_e st_q;
  logic cmp_meta_q, cmp_sync_q, cmp_prev_q;
  logic [PW-1:0] phase_q;
  logic [DW-1:0] inc_q;
  logic [AW-1:0] alt_q;
  logic [dsalt_pkg::PRESS_W-1:0] down_q;
  logic [12:0] dec_q;
  logic [DW-1:0] rom_data;
  logic [DW:0] inc_nx;
  logic start_acc, trip, step, advance, int_end, dis_end, dig_end;

  // comparator is asynchronous to clk, two flops before any use
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_meta_q <= 1'h0;
      cmp_sync_q <= 1'h0;
      cmp_prev_q <= 1'h0;
    end else begin
      cmp_meta_q <= comparator;
      cmp_sync_q <= cmp_meta_q;
      cmp_prev_q <= cmp_sync_q;
    end
  end

  // delta table addressed straight by the altitude counter
  dsalt_delta_rom #(
    .ADDR_W(AW),
    .DATA_W(DW),
    .DEPTH(dsalt_pkg::ALT_ROM_DEPTH)
  ) u_rom (
    .addr(alt_q), // [RULE1] [RULE3]
    .data(rom_data)
  );

  // phase events
  assign start_acc = (st_q == dsalt_pkg::DSALT_IDLE) && start;
  assign trip = (st_q == dsalt_pkg::DSALT_DISCHARGE) && (cmp_sync_q != cmp_prev_q);
  assign int_end = (st_q == dsalt_pkg::DSALT_INTEGRATE) && (phase_q == INT_LAST); // [RULE8]
  assign dis_end = (st_q == dsalt_pkg::DSALT_DISCHARGE) && !trip && (phase_q == DIS_LAST); // [RULE9]
  assign dig_end = (st_q == dsalt_pkg::DSALT_DIGITAL) && (down_q == '0);

  // one pressure increment per counted clock period
  assign step = ((st_q == dsalt_pkg::DSALT_DISCHARGE) && !trip)
              || ((st_q == dsalt_pkg::DSALT_DIGITAL) && (down_q != '0)); // [RULE7] [RULE5]
  assign inc_nx = {1'h0, inc_q} + (DW + 1)'(1);
  assign advance = step && (inc_nx == {1'h0, rom_data}) && (alt_q != ALT_TOP); // [RULE2]
  assign busy = (st_q != dsalt_pkg::DSALT_IDLE);

  // sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= dsalt_pkg::DSALT_IDLE;
    end else begin
      unique case (st_q)
        dsalt_pkg::DSALT_IDLE: begin
          if (start) begin
            st_q <= digital_mode ? dsalt_pkg::DSALT_DIGITAL : dsalt_pkg::DSALT_INTEGRATE;
          end
        end
        dsalt_pkg::DSALT_INTEGRATE: begin
          if (int_end) begin
            st_q <= dsalt_pkg::DSALT_DISCHARGE; // [RULE6]
          end
        end
        dsalt_pkg::DSALT_DISCHARGE: begin
          if (trip || dis_end) begin
            st_q <= dsalt_pkg::DSALT_IDLE;
          end
        end
        dsalt_pkg::DSALT_DIGITAL: begin
          if (dig_end) begin
            st_q <= dsalt_pkg::DSALT_IDLE; // [RULE5]
          end
        end
      endcase
    end
  end

  // phase counter: reused by both analog phases
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= '0;
    end else if (start_acc || int_end) begin
      phase_q <= '0; // [RULE12] [RULE7]
    end else if (st_q == dsalt_pkg::DSALT_INTEGRATE || step) begin
      phase_q <= phase_q + PW'(1); // [RULE7]
    end
  end

  // current switches; input stays on after a trip so the next
  // integration starts with no idle reference charge
  always_ff @(posedge clk) begin
    if (rst) begin
      input_current_en <= 1'h0;
      ref_current_en <= 1'h0;
    end else if (start_acc && !digital_mode) begin
      input_current_en <= 1'h1; // [RULE6]
      ref_current_en <= 1'h0;
    end else if (int_end) begin
      input_current_en <= 1'h0; // [RULE6]
      ref_current_en <= 1'h1;
    end else if (trip || dis_end) begin
      input_current_en <= 1'h1; // [RULE10]
      ref_current_en <= 1'h0;
    end
  end

  // increment and altitude counters
  always_ff @(posedge clk) begin
    if (rst) begin
      inc_q <= '0;
      alt_q <= '0;
    end else if (start_acc) begin
      inc_q <= '0; // [RULE12]
      alt_q <= '0; // [RULE2] [RULE12]
    end else if (advance) begin
      inc_q <= '0; // [RULE3]
      alt_q <= alt_q + AW'(1); // [RULE2]
    end else if (step && alt_q != ALT_TOP) begin
      inc_q <= inc_nx[DW-1:0];
    end
  end

  // digital pressure down counter
  always_ff @(posedge clk) begin
    if (rst) begin
      down_q <= '0;
    end else if (start_acc && digital_mode) begin
      down_q <= digital_pressure; // [RULE5]
    end else if (step && st_q == dsalt_pkg::DSALT_DIGITAL) begin
      down_q <= down_q - PRW'(1); // [RULE5]
    end
  end

  // sign and three bcd digits of hundreds of feet, one step per advance
  function automatic logic [12:0] dec_step(input logic [12:0] v);
    logic neg;
    logic [3:0] d2, d1, d0;
    {neg, d2, d1, d0} = v;
    if (neg) begin
      if (d0 != 4'h0) begin
        d0 = d0 - 4'h1;
      end else begin
        d0 = 4'h9;
        if (d1 != 4'h0) begin
          d1 = d1 - 4'h1;
        end else begin
          d1 = 4'h9;
          d2 = d2 - 4'h1;
        end
      end
      if ({d2, d1, d0} == 12'h000) begin
        neg = 1'h0;
      end
    end else begin
      if (d0 != 4'h9) begin
        d0 = d0 + 4'h1;
      end else begin
        d0 = 4'h0;
        if (d1 != 4'h9) begin
          d1 = d1 + 4'h1;
        end else begin
          d1 = 4'h0;
          d2 = d2 + 4'h1;
        end
      end
    end
    return {neg, d2, d1, d0};
  endfunction

  // counts alongside the binary counter, so no binary to bcd divider
  always_ff @(posedge clk) begin
    if (rst || start_acc) begin
      dec_q <= {dsalt_pkg::dec_preset_neg, dsalt_pkg::DEC_PRESET_D2,
                dsalt_pkg::DEC_PRESET_D1, dsalt_pkg::DEC_PRESET_D0}; // [RULE11]
    end else if (advance) begin
      dec_q <= dec_step(dec_q); // [RULE11]
    end
  end

  // result registers, loaded once as the conversion ends
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'h0;
      overrange <= 1'h0;
      altitude <= '0;
      discharge_period <= '0;
      {dec_negative, dec_digit2, dec_digit1, dec_digit0} <= '0;
    end else begin
      done <= trip || dis_end || dig_end;
      if (trip || dis_end || dig_end) begin
        overrange <= dis_end; // [RULE9]
        altitude <= advance ? alt_q + AW'(1) : alt_q; // [RULE4]
        discharge_period <= dis_end ? phase_q + PW'(1) : phase_q; // [RULE7]
        {dec_negative, dec_digit2, dec_digit1, dec_digit0} <= advance ? dec_step(dec_q) : dec_q;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [PW:0] int_len_q;
  // helper: periods with input current on inside the integration phase
  always_ff @(posedge clk) begin
    if (rst || start_acc) begin
      int_len_q <= '0;
    end else if (st_q == dsalt_pkg::DSALT_INTEGRATE && input_current_en) begin
      int_len_q <= int_len_q + (PW + 1)'(1);
    end
  end

  sequence s_int_last;
    st_q == dsalt_pkg::DSALT_INTEGRATE && phase_q == INT_LAST;
  endsequence
  sequence s_discharging;
    st_q == dsalt_pkg::DSALT_DISCHARGE && ref_current_en && !input_current_en;
  endsequence

  property p_int_len;
    s_int_last |=> (int_len_q == (PW + 1)'(INTEGRATE_CLKS)) ##0 s_discharging;
  endproperty
  a_int_len: assert property (p_int_len) else $error("integration length wrong"); // [RULE8]

  property p_phase_swap;
    s_int_last |=> s_discharging ##1 (ref_current_en || !busy);
  endproperty
  a_phase_swap: assert property (p_phase_swap) else $error("currents not swapped"); // [RULE6]

  property p_trip;
    trip |=> input_current_en && !ref_current_en && !busy && done;
  endproperty
  a_trip: assert property (p_trip) else $error("reference not cut after trip"); // [RULE10]

  property p_dis_max;
    st_q == dsalt_pkg::DSALT_DISCHARGE && phase_q == DIS_LAST && !trip
      |=> done && overrange && discharge_period == PW'(DISCHARGE_CLKS);
  endproperty
  a_dis_max: assert property (p_dis_max) else $error("full scale discharge wrong"); // [RULE9]

  property p_step_gate;
    (alt_q != $past(alt_q) && !$past(start_acc))
      |-> $past(step) && $past(inc_nx) == {1'h0, $past(rom_data)};
  endproperty
  a_step_gate: assert property (p_step_gate) else $error("altitude stepped early"); // [RULE2]

  property p_reload;
    advance |=> inc_q == '0 && rom_data == u_rom.mem[alt_q];
  endproperty
  a_reload: assert property (p_reload) else $error("rom not reloaded"); // [RULE3]

  property p_result;
    (trip || dig_end) |=> done && altitude == $past(alt_q);
  endproperty
  a_result: assert property (p_result) else $error("altitude not held"); // [RULE4]

  property p_digital;
    st_q == dsalt_pkg::DSALT_DIGITAL && down_q != '0
      |=> down_q == $past(down_q) - PRW'(1) && busy;
  endproperty
  a_digital: assert property (p_digital) else $error("down counter stalled"); // [RULE5]

  property p_clear;
    start_acc |=> alt_q == '0 && inc_q == '0 && phase_q == '0 && dec_q[12];
  endproperty
  a_clear: assert property (p_clear) else $error("start did not clear counters"); // [RULE12]

  property p_dec_zero;
    alt_q == AW'(10) |-> dec_q == 13'h0000;
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decimal counter out of step"); // [RULE11]

  property p_rom_width;
    busy |-> rom_data != '0;
  endproperty
  a_rom_width: assert property (p_rom_width) else $error("rom word is zero"); // [RULE1]

endmodule // dsalt_linearizer

`default_nettype wire

// File: test/dsalt_integ_model.sv
`timescale 1ns/1ps
`default_nettype none

// integrator and comparator stand-in: the ramp recrosses the start level
// a commanded number of reference periods into discharge
module dsalt_integ_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // current switches from the sequencer
  input wire logic input_current_en,
  input wire logic ref_current_en,
  // reference periods until the ramp recrosses the start level
  input wire logic [11:0] trip_after,
  // comparator pin
  output logic comparator
);
  logic [11:0] ramp_cnt_q;

  // input charge lifts the ramp above the start level; reference alone pulls it back
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_cnt_q <= 12'h000;
      comparator <= 1'h0;
    end else if (input_current_en && !ref_current_en) begin
      ramp_cnt_q <= 12'h000;
      comparator <= 1'h0;
    end else if (ref_current_en && !input_current_en) begin
      ramp_cnt_q <= ramp_cnt_q + 12'h001;
      // holds its level after the crossing, as a real comparator would
      if (ramp_cnt_q == trip_after) begin
        comparator <= 1'h1;
      end
    end
  end
endmodule // dsalt_integ_model

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic digital_mode = 1'h0;
  logic [10:0] digital_pressure = 11'h000;
  logic [11:0] trip_after = 12'h000;
  logic comparator, input_current_en, ref_current_en, busy, done, overrange;
  logic [8:0] altitude;
  logic [11:0] discharge_period;
  logic dec_negative;
  logic [3:0] dec_digit2, dec_digit1, dec_digit0;
  int num_errors = 0;
  int num_checks = 0;

  // 20 MHz clock
  initial forever #25 clk = ~clk;

  dsalt_linearizer u_dsalt_linearizer (
    .clk(clk), .rst(rst), .start(start), .digital_mode(digital_mode),
    .digital_pressure(digital_pressure), .comparator(comparator),
    .input_current_en(input_current_en), .ref_current_en(ref_current_en),
    .busy(busy), .done(done), .overrange(overrange), .altitude(altitude),
    .discharge_period(discharge_period), .dec_negative(dec_negative),
    .dec_digit2(dec_digit2), .dec_digit1(dec_digit1), .dec_digit0(dec_digit0)
  );

  dsalt_integ_model u_dsalt_integ_model (
    .clk(clk), .rst(rst), .input_current_en(input_current_en),
    .ref_current_en(ref_current_en), .trip_after(trip_after), .comparator(comparator)
  );

  task automatic conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // reference walk of the delta table, one increment at a time
  function automatic int alt_of(input int n);
    int a;
    int acc;
    a = 0;
    acc = 0;
    for (int i = 0; i < n; i++) begin
      acc++;
      if (a < dsalt_pkg::ALT_STEPS && acc == dsalt_pkg::DELTA_MIN
          + ((dsalt_pkg::ALT_ROM_DEPTH - 1 - a) * (dsalt_pkg::DELTA_MAX - dsalt_pkg::DELTA_MIN))
          / (dsalt_pkg::ALT_ROM_DEPTH - 1)) begin
        a++;
        acc = 0;
      end
    end
    return a;
  endfunction

  task automatic check_result(input int n);
    int v;
    v = alt_of(n) - 10;
    check(altitude === 9'(alt_of(n)), "altitude wrong");
    check(dec_negative === (v < 0), "decimal sign wrong");
    v = (v < 0) ? -v : v;
    check({dec_digit2, dec_digit1, dec_digit0} === {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)},
          "decimal digits wrong");
  endtask

  task automatic request(input logic mode, input logic [10:0] press);
    @(posedge clk);
    start <= 1'h1;
    digital_mode <= mode;
    digital_pressure <= press;
    @(posedge clk);
    start <= 1'h0;
    #1;
  endtask

  // bounded wait; a missing done counts against the run
  task automatic wait_done(input int limit);
    int n;
    n = 0;
    while (done !== 1'h1 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(done, "no done");
  endtask

  task automatic analog_conv(input int trip, input logic exp_over);
    int n;
    trip_after <= 12'(trip);
    request(1'h0, 11'h000);
    n = 0;
    while (ref_current_en !== 1'h1 && n < 3000) begin
      if (input_current_en === 1'h1) n++;
      @(posedge clk);
      #1;
    end
    check(n == dsalt_pkg::FIXED_INTEGRATE_CLKS, "integrate length");
    check(input_current_en === 1'h0, "input current on in discharge");
    wait_done(1700);
    check(ref_current_en === 1'h0 && input_current_en === 1'h1, "currents after trip");
    check(overrange === exp_over, "overrange wrong");
    if (exp_over) begin
      check(discharge_period === 12'(dsalt_pkg::DISCHARGE_MAX_CLKS), "full scale");
    end else begin
      check(discharge_period >= 12'(trip) && discharge_period <= 12'(trip + 5),
            "discharge count");
    end
    check_result(int'(discharge_period));
    @(posedge clk);
    #1;
    check(done === 1'h0 && busy === 1'h0, "done not one cycle");
  endtask

  task automatic digital_conv(input int press);
    logic ie;
    logic re;
    ie = input_current_en;
    re = ref_current_en;
    request(1'h1, 11'(press));
    wait_done(2100);
    check(input_current_en === ie && ref_current_en === re, "currents moved");
    check_result(press);
  endtask

  task automatic test_reset;
    check({busy, done, overrange, input_current_en, ref_current_en} === 5'h00
          && altitude === 9'h000 && discharge_period === 12'h000
          && {dec_negative, dec_digit2, dec_digit1, dec_digit0} === 13'h0000,
          "reset state");
  endtask

  // reset in mid integration: all back to idle, later requests still served
  task automatic test_reset_mid;
    request(1'h0, 11'h000);
    repeat (100) @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    test_reset;
  endtask

  // earliest trip, a short one and a long one
  task automatic test_analog;
    int trips[3] = '{0, 5, 800};
    foreach (trips[i]) analog_conv(trips[i], 1'h0);
  endtask

  task automatic test_overrange;
    analog_conv(4095, 1'h1);
  endtask

  // zero shows the decimal preset; 6 reaches the first step and 7 lies one past it
  task automatic test_digital;
    int vals[4] = '{0, 6, 7, 2047};
    foreach (vals[i]) digital_conv(vals[i]);
  endtask

  // start held high: refused while busy, then taken back to back from zero
  task automatic test_restart;
    @(posedge clk);
    start <= 1'h1;
    digital_mode <= 1'h1;
    digital_pressure <= 11'h014;
    @(posedge clk);
    digital_pressure <= 11'h003;
    #1;
    wait_done(100);
    check_result(20);
    @(posedge clk);
    start <= 1'h0;
    #1;
    wait_done(100);
    check_result(3);
    analog_conv(5, 1'h0);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    test_reset;
    test_analog;
    test_overrange;
    test_digital;
    test_reset_mid;
    test_restart;
    conclude;
  end

  // watchdog sized well past the roughly 15k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    conclude;
  end
endmodule // tb_top

`default_nettype wire
